//--- logic/brd_pkg.sv
// brd_pkg: constants, windows and carrier types of the boot remap decoder.
// assumes a single 32-bit processor bus and one core clock domain.
package brd_pkg;

  // memory select regions, index order is also overlap priority (high wins)
  localparam int NUM_MEM    = 4;
  localparam int MEM_ROM    = 0;
  localparam int MEM_PFLASH = 1;
  localparam int MEM_DFLASH = 2;
  localparam int MEM_RAM    = 3;

  // region size code: bytes = MIN_REGION_BYTES << code, 1 kB .. 16 MB
  localparam int          SIZE_CODE_W      = 4;
  localparam logic [3:0]  SIZE_CODE_MAX    = 4'hE;
  localparam logic [31:0] MIN_REGION_BYTES = 32'h0000_0400;
  localparam int          BASE_LSB         = 10;

  // reset map
  localparam logic [31:0] RST_BASE [NUM_MEM] =
    '{32'h0000_0000, 32'h0001_0000, 32'h0001_8800, 32'h0001_9000};
  localparam logic [3:0]  RST_SIZE [NUM_MEM] = '{4'h6, 4'h5, 4'h1, 4'h2};

  // normal map: only boot rom and program flash move
  localparam logic [31:0] NORM_ROM_BASE    = 32'h0001_0000;
  localparam logic [3:0]  NORM_ROM_SIZE    = 4'h2;
  localparam logic [31:0] NORM_PFLASH_BASE = 32'h0000_0000;
  localparam logic [3:0]  NORM_PFLASH_SIZE = 4'h5;

  // target organisation
  localparam int ROM_IMAGE_W     = 12;
  localparam int PFLASH_WORD_W   = 13;
  localparam int PFLASH_PAGE_LSB = 10;
  localparam int PFLASH_PAGE_W   = 5;
  localparam int DFLASH_WORD_W   = 9;
  localparam int DFLASH_PAGE_LSB = 5;
  localparam int DFLASH_PAGE_W   = 6;
  localparam int RAM_WORD_W      = 10;
  localparam int WORD_LSB        = 2;

  // decoder's own configuration window and register offsets
  localparam logic [31:0] CFG_LO            = 32'hFFFF_FE00;
  localparam logic [31:0] CFG_HI            = 32'hFFFF_FEFF;
  localparam logic [7:0]  OFS_MAP_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_REGION_BASE   = 8'h10;
  localparam logic [7:0]  OFS_REGION_END    = 8'h30;
  localparam int          REGION_STRIDE_SH  = 3;
  localparam int          REGION_SIZE_BIT   = 2;
  localparam int          MAPCTRL_NORMAL    = 0;
  localparam int          MAPCTRL_ROMCTL    = 1;

  // fixed peripheral windows
  localparam int NUM_PERIPH = 23;
  localparam logic [31:0] PERIPH_LO [NUM_PERIPH] = '{
    32'h0002_0000, 32'h0003_0000, 32'h0004_0000, 32'h0005_0000, 32'h0006_0000,
    32'h0007_0000, 32'h0008_0000, 32'h0009_0000, 32'h000A_0000, 32'h000B_0000,
    32'h000C_0000, 32'h000D_0000, 32'h000E_0000, 32'hFFF7_EC00, 32'hFFF7_ED00,
    32'hFFF7_F000, 32'hFFF7_F600, 32'hFFF7_FA00, 32'hFFF7_FD00, 32'hFFFF_FD00,
    32'hFFFF_FF20, 32'hFFFF_FF40, 32'hFFFF_FFD0};
  localparam logic [31:0] PERIPH_HI [NUM_PERIPH] = '{
    32'h0002_00FF, 32'h0003_00FF, 32'h0004_00FF, 32'h0005_00FF, 32'h0006_00FF,
    32'h0007_00FF, 32'h0008_00FF, 32'h0009_00FF, 32'h000A_00FF, 32'h000B_00FF,
    32'h000C_00FF, 32'h000D_00FF, 32'h000E_00FF, 32'hFFF7_ECFF, 32'hFFF7_EDFF,
    32'hFFF7_F0FF, 32'hFFF7_F6FF, 32'hFFF7_FAFF, 32'hFFF7_FDFF, 32'hFFFF_FDFF,
    32'hFFFF_FF37, 32'hFFFF_FF50, 32'hFFFF_FFEC};

  typedef enum {MAP_RESET, MAP_NORMAL} brd_map_t;
  typedef enum {CFG_FIRST, CFG_ANSWER} brd_cfg_state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        priv;
    logic [31:0] addr;
    logic [31:0] wdata;
  } brd_req_t;

  typedef struct packed {
    logic        ready;
    logic        error;
    logic [31:0] rdata;
  } brd_rsp_t;

  typedef struct packed {
    logic rom;
    logic pflash;
    logic dflash;
    logic ram;
  } brd_mem_sel_t;

  typedef struct packed {
    logic [ROM_IMAGE_W-1:0]   romByte;
    logic [PFLASH_WORD_W-1:0] pflashWord;
    logic [PFLASH_PAGE_W-1:0] pflashPage;
    logic [DFLASH_WORD_W-1:0] dflashWord;
    logic [DFLASH_PAGE_W-1:0] dflashPage;
    logic [RAM_WORD_W-1:0]    ramWord;
  } brd_local_t;

endpackage

//--- logic/brd_region_match.sv
// brd_region_match: inclusive address range compare for one select window.
// assumes lo and hi are stable for the cycle in which addr is decoded.
module brd_region_match #(
  parameter int AW = 32
) (
  // address under decode
  input  wire logic [AW-1:0] addr,
  // window bounds, both inclusive
  input  wire logic [AW-1:0] lo,
  input  wire logic [AW-1:0] hi,
  // result
  output logic               hit
);
  // range form covers windows that are not power-of-two aligned
  assign hit = (addr >= lo) && (addr <= hi);
endmodule

//--- logic/brd_memory_select_decoder.sv
// brd_memory_select_decoder: memory and peripheral selects for the single processor bus.
// assumes one bus master holding its request until ready, and targets answering via targetReady.
//
// Summary of operation
// - all accesses share one bus; every target owns a distinct address range
// - reset map: boot rom at 0x0..0xFFFF, 4K image mirrored sixteen times
// - reset map: pflash 0x10000, data flash 0x18800, ram 0x19000
// - normal map: pflash at 0x0..0x7FFF, rom from 0x10000; others unchanged
// - pflash is 8k x 32 words with 1 kB erase pages
// - data flash is 512 x 32 with 32-byte pages, target applies ecc
// - data ram is 1k x 32, 4 kB
// - the first 20 peripherals own 256-byte windows at their bases; the last three span 24, 17 and 29 bytes
// - reset runs from boot rom; valid short checksum hands over to pflash
// - failed short checksum: full 32 kB check, valid hands over to pflash
// - no valid checksum: rom keeps control and reaches all memory
// - each memory region is sized 1 kB to 16 MB by configuration
// - every configuration register access costs one wait state
// - configuration writes only accepted from privileged mode
module brd_memory_select_decoder (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // processor bus
  input  brd_pkg::brd_req_t                busReq,
  input  wire logic                        targetReady,
  output brd_pkg::brd_rsp_t                busRsp,
  // target selects and local addresses
  output brd_pkg::brd_mem_sel_t            memSel,
  output logic [brd_pkg::NUM_PERIPH-1:0]   periphSel,
  output brd_pkg::brd_local_t              localAddr,
  // boot status
  output logic                             romInControl
);
  import brd_pkg::*;

  // configuration state
  logic [31:0]            regionBase_reg [NUM_MEM];
  logic [SIZE_CODE_W-1:0] regionSize_reg [NUM_MEM];
  brd_map_t               mapMode_reg;
  brd_cfg_state_t         cfgState_reg;
  logic [31:0]            cfgRdata_reg;

  // decode nets
  wire logic [31:0]            addr = busReq.addr;
  logic      [31:0]            regionHi  [NUM_MEM];
  logic      [31:0]            regionOfs [NUM_MEM];
  logic      [NUM_MEM-1:0]     memHit;
  logic      [NUM_PERIPH-1:0]  periphHit;
  logic                        cfgWinHit;
  logic                        cfgAccess;
  logic                        anyMem;
  logic                        anyPeriph;
  logic                        unmapped;
  logic                        cfgAnswer;
  logic                        cfgCommit;
  logic                        cfgDenied;
  logic [7:0]                  cfgOfs;
  logic                        cfgIsMap;
  logic                        cfgIsRegion;
  logic [1:0]                  cfgRegion;
  logic                        cfgIsSize;
  logic [SIZE_CODE_W-1:0]      wrSize;
  logic [31:0]                 wrBase;
  logic [31:0]                 cfgReadValue;

  // region bounds follow the configured base and size code
  genvar g;
  generate
    for (g = 0; g < NUM_MEM; g++)
    begin : g_mem
      assign regionHi[g]  = regionBase_reg[g]
                            + ((MIN_REGION_BYTES << regionSize_reg[g]) - 32'h1);
      assign regionOfs[g] = addr - regionBase_reg[g];
      brd_region_match #(.AW(32)) u_mem (
        .addr (addr),
        .lo   (regionBase_reg[g]),
        .hi   (regionHi[g]),
        .hit  (memHit[g])
      );
    end
    for (g = 0; g < NUM_PERIPH; g++)
    begin : g_periph
      brd_region_match #(.AW(32)) u_periph (
        .addr (addr),
        .lo   (PERIPH_LO[g]),
        .hi   (PERIPH_HI[g]),
        .hit  (periphHit[g])
      );
    end
  endgenerate

  brd_region_match #(.AW(32)) u_cfg (
    .addr (addr),
    .lo   (CFG_LO),
    .hi   (CFG_HI),
    .hit  (cfgWinHit)
  );

  // one select at most: own window first so a bad map can always be repaired,
  // then memories (highest index wins on overlap), then peripherals
  assign cfgAccess     = busReq.valid && cfgWinHit;
  assign memSel.ram    = busReq.valid && !cfgWinHit && memHit[MEM_RAM];
  assign memSel.dflash = busReq.valid && !cfgWinHit && memHit[MEM_DFLASH]
                         && !memHit[MEM_RAM];
  assign memSel.pflash = busReq.valid && !cfgWinHit && memHit[MEM_PFLASH]
                         && !memHit[MEM_DFLASH] && !memHit[MEM_RAM];
  assign memSel.rom    = busReq.valid && !cfgWinHit && memHit[MEM_ROM]
                         && !memHit[MEM_PFLASH] && !memHit[MEM_DFLASH]
                         && !memHit[MEM_RAM];
  assign anyMem        = |memHit;
  assign anyPeriph     = |periphHit;
  assign periphSel     = (busReq.valid && !cfgWinHit && !anyMem) ? periphHit
                                                                 : '0;
  assign unmapped      = busReq.valid && !cfgWinHit && !anyMem && !anyPeriph;

  // offsets inside each target; the rom wraps its 4K image over the region
  assign localAddr.romByte    = regionOfs[MEM_ROM][ROM_IMAGE_W-1:0];
  assign localAddr.pflashWord =
    regionOfs[MEM_PFLASH][WORD_LSB +: PFLASH_WORD_W];
  assign localAddr.pflashPage =
    regionOfs[MEM_PFLASH][PFLASH_PAGE_LSB +: PFLASH_PAGE_W];
  assign localAddr.dflashWord =
    regionOfs[MEM_DFLASH][WORD_LSB +: DFLASH_WORD_W];
  assign localAddr.dflashPage =
    regionOfs[MEM_DFLASH][DFLASH_PAGE_LSB +: DFLASH_PAGE_W];
  assign localAddr.ramWord    = regionOfs[MEM_RAM][WORD_LSB +: RAM_WORD_W];

  // configuration register decode
  assign cfgOfs      = addr[7:0];
  assign cfgIsMap    = (cfgOfs == OFS_MAP_CTRL);
  assign cfgIsRegion = (cfgOfs >= OFS_REGION_BASE) && (cfgOfs < OFS_REGION_END)
                       && (cfgOfs[1:0] == 2'h0);
  assign cfgRegion   = 2'((cfgOfs - OFS_REGION_BASE) >> REGION_STRIDE_SH);
  assign cfgIsSize   = cfgOfs[REGION_SIZE_BIT];

  // second cycle of a config access answers; the first only inserts the wait
  assign cfgAnswer = cfgAccess && (cfgState_reg == CFG_ANSWER);
  assign cfgDenied = cfgAnswer && busReq.write && !busReq.priv;
  assign cfgCommit = cfgAnswer && busReq.write && busReq.priv;

  // oversized codes clamp to 16 MB, bases keep 1 kB granularity
  assign wrSize = (busReq.wdata[SIZE_CODE_W-1:0] > SIZE_CODE_MAX)
                  ? SIZE_CODE_MAX : busReq.wdata[SIZE_CODE_W-1:0];
  assign wrBase = {busReq.wdata[31:BASE_LSB], {BASE_LSB{1'b0}}};

  // read mux: unused offsets in the window read as zero
  always_comb
  begin
    cfgReadValue = 32'h0000_0000;
    if (cfgIsMap)
    begin
      cfgReadValue[MAPCTRL_NORMAL] = (mapMode_reg == MAP_NORMAL);
      cfgReadValue[MAPCTRL_ROMCTL] = (mapMode_reg == MAP_RESET);
    end
    else if (cfgIsRegion && cfgIsSize)
    begin
      cfgReadValue[SIZE_CODE_W-1:0] = regionSize_reg[cfgRegion];
    end
    else if (cfgIsRegion)
    begin
      cfgReadValue = regionBase_reg[cfgRegion];
    end
  end

  // wait-state sequencer for the decoder's own registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cfgState_reg <= CFG_FIRST;
      cfgRdata_reg <= 32'h0000_0000;
    end
    else
    begin
      case (cfgState_reg)
        CFG_FIRST:
        begin
          if (cfgAccess)
          begin
            cfgState_reg <= CFG_ANSWER;
            cfgRdata_reg <= cfgReadValue;
          end
        end
        CFG_ANSWER:
        begin
          cfgState_reg <= CFG_FIRST;
        end
        default:
        begin
          cfgState_reg <= CFG_FIRST;
        end
      endcase
    end
  end

  // map state: the whole map swaps in one edge at the end of the write, so
  // the next decoded access already sees the new map and never a blend
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      mapMode_reg <= MAP_RESET;
      for (int i = 0; i < NUM_MEM; i++)
      begin
        regionBase_reg[i] <= RST_BASE[i];
        regionSize_reg[i] <= RST_SIZE[i];
      end
    end
    else if (cfgCommit && cfgIsMap)
    begin
      if (busReq.wdata[MAPCTRL_NORMAL])
      begin
        mapMode_reg                 <= MAP_NORMAL;
        regionBase_reg[MEM_ROM]     <= NORM_ROM_BASE;
        regionSize_reg[MEM_ROM]     <= NORM_ROM_SIZE;
        regionBase_reg[MEM_PFLASH]  <= NORM_PFLASH_BASE;
        regionSize_reg[MEM_PFLASH]  <= NORM_PFLASH_SIZE;
      end
      else
      begin
        mapMode_reg                 <= MAP_RESET;
        regionBase_reg[MEM_ROM]     <= RST_BASE[MEM_ROM];
        regionSize_reg[MEM_ROM]     <= RST_SIZE[MEM_ROM];
        regionBase_reg[MEM_PFLASH]  <= RST_BASE[MEM_PFLASH];
        regionSize_reg[MEM_PFLASH]  <= RST_SIZE[MEM_PFLASH];
      end
    end
    else if (cfgCommit && cfgIsRegion && cfgIsSize)
    begin
      regionSize_reg[cfgRegion] <= wrSize;
    end
    else if (cfgCommit && cfgIsRegion)
    begin
      regionBase_reg[cfgRegion] <= wrBase;
    end
  end

  // rom keeps control until firmware, having found a valid short or full
  // checksum, selects the normal map; meanwhile the reset map reaches every
  // memory and window, which the rom's bus loader relies on
  assign romInControl = (mapMode_reg == MAP_RESET);

  // answer: config cycles wait once, unmapped and denied answer with error,
  // everything else takes the selected target's own ready
  assign busRsp.ready = cfgAccess ? cfgAnswer
                      : (unmapped ? busReq.valid : (busReq.valid && targetReady));
  assign busRsp.error = unmapped || cfgDenied;
  assign busRsp.rdata = cfgRdata_reg;

endmodule

//--- bench/brd_assertions.sv
// brd_assertions: port checks of the boot remap decoder.
// assumes default region bases and sizes while targets are accessed.
module brd_assertions (
  // clock and reset
  input wire logic                       core_clk,
  input wire logic                       rst,
  // bus, selects and status
  input brd_pkg::brd_req_t               busReq,
  input wire logic                       targetReady,
  input brd_pkg::brd_rsp_t               busRsp,
  input brd_pkg::brd_mem_sel_t           memSel,
  input wire logic [brd_pkg::NUM_PERIPH-1:0] periphSel,
  input brd_pkg::brd_local_t             localAddr,
  input wire logic                       romInControl
);
  timeunit 1ns;
  timeprecision 1ps;
  import brd_pkg::*;
  // decoded request facts shared by the checks
  wire logic        vld   = busReq.valid;
  wire logic [31:0] adr   = busReq.addr;
  wire logic        inCfg = vld && adr >= CFG_LO && adr <= CFG_HI;
  wire logic [31:0] ofsD  = adr - 32'h0001_8800;
  wire logic        anySel = (|memSel) || (|periphSel);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // first cycle of a config access: the previous cycle did not hold one open
  sequence cfgFirst;
    inCfg && !$past(inCfg && !busRsp.ready);
  endsequence
  sequence userCfgWr;
    inCfg && busReq.write && !busReq.priv && busRsp.ready;
  endsequence
  cfg_wait_state_a: assert property (cfgFirst |-> !busRsp.ready ##1 busRsp.ready)
    else $error("config access not answered after one wait");
  user_write_a: assert property (userCfgWr |-> busRsp.error ##1 $stable(romInControl))
    else $error("user mode config write took effect");
  map_switch_a: assert property ($fell(romInControl) |->
    $past(inCfg && busReq.write && busReq.priv && busRsp.ready && busReq.wdata[0]))
    else $error("map changed without a completed write");
  one_select_a: assert property ($onehot0({memSel, periphSel}))
    else $error("more than one target selected");
  unmapped_err_a: assert property (vld && !inCfg && !anySel |-> busRsp.ready && busRsp.error)
    else $error("unmapped access not refused");
  target_ready_a: assert property (vld && !inCfg && anySel |->
    busRsp.ready == targetReady && !busRsp.error)
    else $error("target ready not passed through");
  rom_mirror_a: assert property (romInControl && vld && adr[31:16] == 16'h0000 |->
    memSel.rom && localAddr.romByte == adr[11:0])
    else $error("reset map boot rom mirror wrong");
  pflash_reset_a: assert property (romInControl && vld && adr[31:15] == 17'h00002 |->
    memSel.pflash && localAddr.pflashWord == adr[14:2])
    else $error("reset map program flash wrong");
  normal_map_a: assert property (!romInControl && vld && adr[31:15] == 17'h0 |->
    memSel.pflash && localAddr.pflashPage == adr[14:10])
    else $error("normal map program flash wrong");
  dflash_word_a: assert property (vld && adr >= 32'h0001_8800 && adr <= 32'h0001_8FFF |->
    memSel.dflash && localAddr.dflashWord == ofsD[10:2] && localAddr.dflashPage == ofsD[10:5])
    else $error("data flash decode wrong");
  ram_word_a: assert property (vld && adr[31:12] == 20'h00019 |->
    memSel.ram && localAddr.ramWord == adr[11:2])
    else $error("data ram decode wrong");
  periph_window_a: assert property (vld && adr[31:8] == 24'h000200 |-> periphSel == 23'h1)
    else $error("first peripheral window wrong");
endmodule

bind brd_memory_select_decoder brd_assertions i_brd_assertions (
  .core_clk(core_clk), .rst(rst), .busReq(busReq), .targetReady(targetReady),
  .busRsp(busRsp), .memSel(memSel), .periphSel(periphSel), .localAddr(localAddr),
  .romInControl(romInControl));

//--- bench/brd_cpu_model.sv
// brd_cpu_model: the single bus master, plus the ready of the selected target.
// assumes access is called just after a rising edge, one access at a time.
module brd_cpu_model (
  // clock
  input wire logic                           core_clk,
  // bus toward the decoder
  output brd_pkg::brd_req_t                  busReq,
  output logic                               targetReady,
  input brd_pkg::brd_rsp_t                   busRsp,
  // selects captured with the answer
  input brd_pkg::brd_mem_sel_t               memSel,
  input wire logic [brd_pkg::NUM_PERIPH-1:0] periphSel,
  input brd_pkg::brd_local_t                 localAddr
);
  timeunit 1ns;
  timeprecision 1ps;
  import brd_pkg::*;
  int                    tgtDly;
  int                    waitCnt;
  int                    lastCyc;
  brd_rsp_t              lastRsp;
  brd_mem_sel_t          lastSel;
  logic [NUM_PERIPH-1:0] lastPer;
  brd_local_t            lastLoc;
  initial
  begin
    busReq = '0;
    tgtDly = 0;
  end
  // target answers tgtDly cycles into each access, so slow targets are covered too
  always_ff @(posedge core_clk)
    waitCnt <= (busReq.valid && !busRsp.ready) ? waitCnt + 1 : 0;
  assign targetReady = busReq.valid && waitCnt >= tgtDly;
  // request held until the ready edge; lastCyc is -1 when no answer came
  task automatic access(input logic w, input logic p, input logic [31:0] a,
                        input logic [31:0] d, input int dly);
    int n;
    n = 0;
    tgtDly = dly;
    busReq = '{valid: 1'b1, write: w, priv: p, addr: a, wdata: d};
    @(negedge core_clk);
    while (busRsp.ready !== 1'b1 && n < 40)
    begin
      n++;
      @(negedge core_clk);
    end
    lastRsp = busRsp;
    lastSel = memSel;
    lastPer = periphSel;
    lastLoc = localAddr;
    lastCyc = (busRsp.ready === 1'b1) ? n : -1;
    @(posedge core_clk);
    #1;
  endtask
  // released lines show the inverse of their last value, not a stale copy
  task automatic idle();
    busReq = '{valid: 1'b0, write: ~busReq.write, priv: ~busReq.priv,
               addr: ~busReq.addr, wdata: ~busReq.wdata};
    @(posedge core_clk);
    #1;
  endtask
endmodule

//--- bench/tb.sv
// tb: directed checks of both address maps, peripheral windows and config access.
// assumes the bound checker watches the decoder ports throughout.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import brd_pkg::*;
  logic                  core_clk;
  logic                  rst;
  brd_req_t              busReq;
  logic                  targetReady;
  brd_rsp_t              busRsp;
  brd_mem_sel_t          memSel;
  logic [NUM_PERIPH-1:0] periphSel;
  brd_local_t            localAddr;
  logic                  romInControl;
  int                    miscompares;
  int                    compares;
  brd_memory_select_decoder i_brd_memory_select_decoder (.core_clk(core_clk), .rst(rst),
    .busReq(busReq), .targetReady(targetReady), .busRsp(busRsp), .memSel(memSel),
    .periphSel(periphSel), .localAddr(localAddr), .romInControl(romInControl));
  brd_cpu_model i_brd_cpu_model (.core_clk(core_clk), .busReq(busReq),
    .targetReady(targetReady), .busRsp(busRsp), .memSel(memSel), .periphSel(periphSel),
    .localAddr(localAddr));
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one bus access; a missing answer ends the run
  task automatic acc(input logic w, input logic p, input logic [31:0] a,
                     input logic [31:0] d, input int dly);
    i_brd_cpu_model.access(w, p, a, d, dly);
    if (i_brd_cpu_model.lastCyc < 0)
    begin
      miscompares++;
      wrap_up();
    end
  endtask
  task automatic look(input logic [31:0] a, input logic [3:0] s, input logic [22:0] p,
                      input logic e);
    acc(1'b0, 1'b1, a, 32'h0, 1);
    chk("memSel", {28'h0, s}, {28'h0, i_brd_cpu_model.lastSel});
    chk("periphSel", {9'h0, p}, {9'h0, i_brd_cpu_model.lastPer});
    chk("error", {31'h0, e}, {31'h0, i_brd_cpu_model.lastRsp.error});
  endtask
  task automatic cfgRead(input logic [7:0] ofs, input logic [31:0] exp);
    acc(1'b0, 1'b1, CFG_LO + ofs, 32'h0, 0);
    chk("cfgWait", 32'h1, i_brd_cpu_model.lastCyc);
    chk("rdata", exp, i_brd_cpu_model.lastRsp.rdata);
  endtask
  // config write: always one wait state, error only for user mode
  task automatic cfgWrite(input logic p, input logic [7:0] ofs, input logic [31:0] d);
    acc(1'b1, p, CFG_LO + ofs, d, 0);
    chk("cfgWait", 32'h1, i_brd_cpu_model.lastCyc);
    chk("cfgError", {31'h0, !p}, {31'h0, i_brd_cpu_model.lastRsp.error});
  endtask
  // sync reset held 16 cycles with the bus idle
  task automatic do_reset();
    rst = 1'b1;
    repeat (16) @(posedge core_clk);
    #1 rst = 1'b0;
  endtask
  task automatic t_reset_map();
    look(32'h0000_5ABC, 4'h8, '0, 1'b0);
    chk("romByte", 32'hABC, {20'h0, i_brd_cpu_model.lastLoc.romByte});
    look(32'h0000_FFFC, 4'h8, '0, 1'b0);
    look(32'h0001_7FFC, 4'h4, '0, 1'b0);
    chk("pflashWord", 32'h1FFF, {19'h0, i_brd_cpu_model.lastLoc.pflashWord});
    look(32'h0001_8000, 4'h0, '0, 1'b1);
    look(32'h0001_8FE0, 4'h2, '0, 1'b0);
    chk("dflashPage", 32'h3F, {26'h0, i_brd_cpu_model.lastLoc.dflashPage});
    look(32'h0001_9FFC, 4'h1, '0, 1'b0);
    chk("ramWord", 32'h3FF, {22'h0, i_brd_cpu_model.lastLoc.ramWord});
    acc(1'b0, 1'b1, 32'h0001_9000, 32'h0, 3);
    chk("slowTarget", 32'h3, i_brd_cpu_model.lastCyc);
    chk("romInControl", 32'h1, {31'h0, romInControl});
  endtask
  task automatic t_periph();
    for (int i = 0; i < NUM_PERIPH; i++)
    begin
      look(PERIPH_LO[i], 4'h0, 23'h1 << i, 1'b0);
      look(PERIPH_HI[i], 4'h0, 23'h1 << i, 1'b0);
    end
    look(32'h0002_0100, 4'h0, '0, 1'b1);
  endtask
  task automatic t_cfg();
    cfgRead(OFS_MAP_CTRL, 32'h2);
    cfgRead(8'h28, 32'h0001_9000);
    cfgRead(8'h2C, 32'h2);
    cfgWrite(1'b1, 8'h2C, 32'hF);
    cfgRead(8'h2C, 32'hE);
    cfgWrite(1'b1, 8'h2C, 32'h2);
    // move the ram window: low base bits are dropped, decode follows at once
    cfgWrite(1'b1, 8'h28, 32'h0002_43FF);
    cfgRead(8'h28, 32'h0002_4000);
    look(32'h0002_4004, 4'h1, '0, 1'b0);
    chk("ramWord", 32'h1, {22'h0, i_brd_cpu_model.lastLoc.ramWord});
    cfgWrite(1'b1, 8'h28, 32'h0001_9000);
    cfgWrite(1'b0, OFS_MAP_CTRL, 32'h1);
    chk("userError", 32'h1, {31'h0, i_brd_cpu_model.lastRsp.error});
    look(32'h0000_0100, 4'h8, '0, 1'b0);
  endtask
  task automatic t_remap();
    cfgWrite(1'b1, OFS_MAP_CTRL, 32'h1);
    look(32'h0000_0100, 4'h4, '0, 1'b0);
    chk("romInControl", 32'h0, {31'h0, romInControl});
    look(32'h0000_8000, 4'h0, '0, 1'b1);
    look(32'h0001_0010, 4'h8, '0, 1'b0);
    look(32'h0001_8800, 4'h2, '0, 1'b0);
    look(32'h0001_9000, 4'h1, '0, 1'b0);
    cfgWrite(1'b1, OFS_MAP_CTRL, 32'h0);
    look(32'h0000_0100, 4'h8, '0, 1'b0);
    cfgWrite(1'b1, OFS_MAP_CTRL, 32'h1);
    i_brd_cpu_model.idle();
    do_reset();
    look(32'h0000_0100, 4'h8, '0, 1'b0);
    chk("romInControl", 32'h1, {31'h0, romInControl});
  endtask
  initial
  begin
    miscompares = 0;
    compares = 0;
    do_reset();
    t_reset_map();
    t_periph();
    t_cfg();
    t_remap();
    wrap_up();
  end
endmodule
